// *** logic/usx_pkg.sv ***
/*
 * shared constants and types for the serial transmitter: register offsets,
 * field positions, reset values, frame constants and the configuration carrier.
 * assumes a 32-bit classic wishbone bus with byte addresses and 8-bit registers in lane 0.
 */
`default_nettype none
package usx_pkg;

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [4:0] OFS_CTRL_A   = 5'h00; // status: flags, double speed
	localparam logic [4:0] OFS_CTRL_B   = 5'h04; // enables, ninth bit, clock direction
	localparam logic [4:0] OFS_CTRL_C   = 5'h08; // frame format, mode, polarity
	localparam logic [4:0] OFS_DATA     = 5'h0C; // transmit buffer (writes only)
	localparam logic [4:0] OFS_BAUD_LO  = 5'h10; // divisor bits 7:0
	localparam logic [4:0] OFS_BAUD_HI  = 5'h14; // divisor bits 11:8

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int A_DOUBLE_SPEED   = 1; // double_speed_bit
	localparam int A_BUF_EMPTY      = 5; // tx_buffer_empty_flag
	localparam int A_TX_COMPLETE    = 6; // tx_complete_flag
	localparam int B_NINTH_TX       = 0; // ninth_tx_bit
	localparam int B_CLK_MASTER     = 1; // drive the clock pin in sync mode
	localparam int B_TX_ENABLE      = 3; // tx_enable_bit
	localparam int B_EMPTY_IE       = 5; // buffer_empty_irq_enable
	localparam int B_TXC_IE         = 6; // tx_complete_irq_enable
	localparam int C_POLARITY       = 0; // clock_polarity_bit
	localparam int C_SIZE_LO        = 1; // char_size_field, 3 bits
	localparam int C_STOP2          = 4; // stop_bits_select
	localparam int C_PARITY_LO      = 5; // parity_mode_field, 2 bits
	localparam int C_SYNC           = 7; // synchronous mode

	// ************************************************************
	// reset values and frame constants
	// ************************************************************
	localparam logic [7:0] RST_CTRL_B  = 8'h00;
	localparam logic [7:0] RST_CTRL_C  = 8'h06; // eight data bits
	localparam logic [2:0] SIZE_NINE   = 3'h7;  // char size code for nine bits
	localparam logic [4:0] DIV_NORMAL  = 5'h10; // baud ticks per bit, normal async
	localparam logic [4:0] DIV_DOUBLE  = 5'h08; // baud ticks per bit, double speed
	localparam int         DIVISOR_W   = 12;    // width of the baud divisor

	// configuration carrier decoded from the control registers
	typedef struct packed {
		logic       sync;    // synchronous mode
		logic       master;  // this end makes the clock
		logic       pol;     // clock polarity
		logic [1:0] parity;  // parity mode
		logic       stop2;   // two stop bits
		logic [2:0] size;    // character size code
		logic       dbl;     // double speed
	} usx_cfg_t;

	// transmitter sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_START = 5'b00010,
		ST_DATA  = 5'b00100,
		ST_PAR   = 5'b01000,
		ST_STOP  = 5'b10000
	} usx_state_t;

endpackage
`default_nettype wire

// *** logic/usx_baud.sv ***
/*
 * baud rate down-counter: reloads from the divisor at zero or on a reload
 * strobe and emits a one-cycle tick at each zero not met by a reload strobe.
 * assumes the divisor is stable except around a reload strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module usx_baud
	import usx_pkg::*;
#(
	parameter int W = DIVISOR_W // divisor width
) (
	input  wire logic         clock,  // system clock
	input  wire logic         rst_n,  // async reset, active low
	input  wire logic         ce,     // clock enable
	input  wire logic [W-1:0] div,    // divisor value
	input  wire logic         reload, // divisor low byte written
	output logic              tick    // one-cycle pulse at zero
);

	// ************************************************************
	// counter
	// ************************************************************
	logic [W-1:0] cnt_r;    // current count
	logic [W-1:0] cnt_nxt;  // next count
	logic         tick_r;   // registered tick
	logic         tick_nxt; // next tick

	// next count: a reload restarts the period without a tick
	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (reload) begin
			cnt_nxt = div;
		end else if (cnt_r == '0) begin
			cnt_nxt  = div;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// registers, frozen while ce is low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else if (ce) begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;

endmodule // usx_baud
`default_nettype wire

// *** logic/usx_tx.sv ***
/*
 * serial transmitter with a one-character buffer, parity, 5 to 9 data bits,
 * one or two stop bits, async or clocked sync operation, and a wishbone slave.
 * assumes classic wishbone single cycles and pin inputs synchronous to clock.
 */
`timescale 1ns/1ns
`default_nettype none
module usx_tx
	import usx_pkg::*;
(
	input  wire logic        clock,         // system clock, 100 MHz
	input  wire logic        rst_n,         // async reset, active low
	input  wire logic        ce,            // clock enable, freezes all state
	input  wire logic        wb_cyc_i,      // wishbone cycle
	input  wire logic        wb_stb_i,      // wishbone strobe
	input  wire logic        wb_we_i,       // wishbone write
	input  wire logic [4:0]  wb_adr_i,      // wishbone byte address
	input  wire logic [3:0]  wb_sel_i,      // wishbone byte selects
	input  wire logic [31:0] wb_dat_i,      // wishbone write data
	output logic      [31:0] wb_dat_o,      // wishbone read data
	output logic             wb_ack_o,      // wishbone acknowledge
	output logic             serial_out,    // serial output level
	output logic             serial_oe_n,   // serial pin drive, low while driven
	input  wire logic        xck_in,        // clock pin input level
	output logic             xck_out,       // clock pin output level
	output logic             xck_oe_n,      // clock pin drive, low while driven
	input  wire logic        txc_irq_ack,   // complete interrupt serviced pulse
	output logic             irq_buf_empty, // buffer-empty interrupt request
	output logic             irq_tx_done    // transmit-complete interrupt request
);

	// ************************************************************
	// decode helpers
	// ************************************************************

	// number of data bits for a size code; reserved codes send eight
	function automatic logic [3:0] char_bits(input logic [2:0] size);
		unique case (size)
			3'h0:      char_bits = 4'h5;
			3'h1:      char_bits = 4'h6;
			3'h2:      char_bits = 4'h7;
			SIZE_NINE: char_bits = 4'h9;
			default:   char_bits = 4'h8;
		endcase
	endfunction

	// mask of bits actually sent for a size code
	function automatic logic [8:0] char_mask(input logic [2:0] size);
		char_mask = 9'h1FF >> (4'h9 - char_bits(size));
	endfunction

	// ************************************************************
	// bus and register state
	// ************************************************************
	logic [7:0]           ctrl_b_r, ctrl_b_nxt;   // control b
	logic [7:0]           ctrl_c_r, ctrl_c_nxt;   // control c
	logic                 dbl_r, dbl_nxt;         // double speed
	logic [DIVISOR_W-1:0] baud_r, baud_nxt;       // baud divisor
	logic                 ack_r, ack_nxt;         // bus acknowledge
	logic [31:0]          rdat_r, rdat_nxt;       // bus read data
	logic                 txc_r, txc_nxt;         // transmit complete flag
	logic                 full_r, full_nxt;       // buffer holds a character
	logic [8:0]           buf_r, buf_nxt;         // buffered character
	logic                 active_r, active_nxt;   // transmitter owns the pins
	logic                 irq_e_r, irq_e_nxt;     // empty interrupt register
	logic                 irq_c_r, irq_c_nxt;     // complete interrupt register
	logic                 access;                 // request taken this cycle
	logic                 wr;                     // write taken on lane 0
	logic                 wr_data;                // data location write
	logic                 baud_reload;            // low divisor byte written
	logic                 frame_done;             // frame ended, nothing pending
	logic                 load;                   // buffer moves to the shifter
	usx_cfg_t             cfg;                    // decoded configuration
	usx_state_t           state_r, state_nxt;     // sequencer state

	assign access      = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr          = access && wb_we_i && wb_sel_i[0];
	assign wr_data     = wr && (wb_adr_i == OFS_DATA);
	assign baud_reload = wr && (wb_adr_i == OFS_BAUD_LO);
	assign cfg = '{sync: ctrl_c_r[C_SYNC], master: ctrl_b_r[B_CLK_MASTER],
		pol: ctrl_c_r[C_POLARITY], parity: ctrl_c_r[C_PARITY_LO +: 2],
		stop2: ctrl_c_r[C_STOP2], size: ctrl_c_r[C_SIZE_LO +: 3], dbl: dbl_r};

	// register writes, read mux, flags and interrupts
	always_comb begin
		ctrl_b_nxt = ctrl_b_r;
		ctrl_c_nxt = ctrl_c_r;
		dbl_nxt    = dbl_r;
		baud_nxt   = baud_r;
		buf_nxt    = buf_r;
		ack_nxt    = access; // one-cycle answer, dropped the cycle after
		rdat_nxt   = rdat_r;
		if (wr) begin
			unique case (wb_adr_i)
				OFS_CTRL_A:  dbl_nxt    = wb_dat_i[A_DOUBLE_SPEED];
				OFS_CTRL_B:  ctrl_b_nxt = wb_dat_i[7:0];
				OFS_CTRL_C:  ctrl_c_nxt = wb_dat_i[7:0];
				OFS_BAUD_LO: baud_nxt[7:0] = wb_dat_i[7:0];
				OFS_BAUD_HI: baud_nxt[DIVISOR_W-1:8] = wb_dat_i[DIVISOR_W-9:0];
				default: ;   // unmapped or data: no register field here
			endcase
		end
		if (wr_data) begin
			// the ninth bit is latched from control b, written earlier
			buf_nxt = {ctrl_b_r[B_NINTH_TX], wb_dat_i[7:0]};
		end
		if (access && !wb_we_i) begin
			unique case (wb_adr_i)
				OFS_CTRL_A:  rdat_nxt = {24'h000000, 1'b0, txc_r, !full_r, 3'h0,
					dbl_r, 1'b0};
				OFS_CTRL_B:  rdat_nxt = {24'h000000, ctrl_b_r};
				OFS_CTRL_C:  rdat_nxt = {24'h000000, ctrl_c_r};
				OFS_BAUD_LO: rdat_nxt = {24'h000000, baud_r[7:0]};
				OFS_BAUD_HI: rdat_nxt = {24'h000000, 4'h0, baud_r[DIVISOR_W-1:8]};
				default:     rdat_nxt = 32'h00000000; // unmapped and data read zero
			endcase
		end
		// a write sets the buffer even if a load takes the old one
		full_nxt = wr_data ? 1'b1 : (load ? 1'b0 : full_r);
		// set wins over both clears
		txc_nxt = txc_r;
		if (txc_irq_ack || (wr && wb_adr_i == OFS_CTRL_A && wb_dat_i[A_TX_COMPLETE])) begin
			txc_nxt = 1'b0;
		end
		if (frame_done) begin
			txc_nxt = 1'b1;
		end
		// enabling is immediate, disabling waits for an empty pipe
		active_nxt = active_r;
		if (ctrl_b_r[B_TX_ENABLE]) begin
			active_nxt = 1'b1;
		end else if (state_r == ST_IDLE && !full_r) begin
			active_nxt = 1'b0;
		end
		irq_e_nxt = ctrl_b_nxt[B_EMPTY_IE] && !full_nxt;
		irq_c_nxt = ctrl_b_nxt[B_TXC_IE] && txc_nxt;
	end

	// ************************************************************
	// bit timing
	// ************************************************************
	logic       baud_tick;        // baud generator output
	logic [4:0] ps_r, ps_nxt;     // async ticks within a bit
	logic       xck_r, xck_nxt;   // master clock pin level
	logic       xs1_r, xs2_r, xs3_r; // clock pin sampling chain
	logic       bit_tick;         // one bit time elapsed
	logic       sync_master;      // this end drives the clock pin

	usx_baud #(.W(DIVISOR_W)) u_baud (
		.clock  (clock),
		.rst_n  (rst_n),
		.ce     (ce),
		.div    (baud_r),
		.reload (baud_reload),
		.tick   (baud_tick)
	);

	assign sync_master = cfg.sync && cfg.master && active_nxt;

	// prescaler and master clock toggle
	always_comb begin
		ps_nxt   = ps_r;
		xck_nxt  = xck_r;
		bit_tick = 1'b0;
		if (cfg.sync) begin
			ps_nxt = 5'h00;
			if (cfg.master) begin
				if (baud_tick && active_r) begin
					xck_nxt  = !xck_r; // two baud ticks per bit
					// data changes on rising edge for polarity 0
					bit_tick = (!xck_r) != cfg.pol;
				end
			end else begin
				// slave: a change edge of the sampled pin
				bit_tick = (xs2_r != xs3_r) && (xs2_r != cfg.pol);
			end
		end else if (baud_tick) begin
			if (ps_r == (cfg.dbl ? DIV_DOUBLE : DIV_NORMAL) - 5'h01) begin
				ps_nxt   = 5'h00;
				bit_tick = 1'b1;
			end else begin
				ps_nxt = ps_r + 5'h01;
			end
		end
	end

	// ************************************************************
	// frame sequencer
	// ************************************************************
	logic [8:0] sh_r, sh_nxt;       // data still to send
	logic       par_r, par_nxt;     // parity of the character
	logic [3:0] cnt_r, cnt_nxt;     // data bits sent
	logic       stp_r, stp_nxt;     // first stop bit done
	logic       out_r, out_nxt;     // serial line level
	logic [8:0] masked;             // buffered character, upper bits cut

	// the parity is taken from the masked character, so unused bits never leak in
	assign masked = buf_r & char_mask(cfg.size);

	// per-bit transitions; a load restarts with the start bit
	always_comb begin
		state_nxt  = state_r;
		sh_nxt     = sh_r;
		par_nxt    = par_r;
		cnt_nxt    = cnt_r;
		stp_nxt    = stp_r;
		out_nxt    = out_r;
		load       = 1'b0;
		frame_done = 1'b0;
		if (!active_r) begin
			state_nxt = ST_IDLE;
			out_nxt   = 1'b1;
		end else if (bit_tick) begin
			unique case (state_r)
				ST_IDLE: begin
					load = full_r;
				end
				ST_START: begin
					out_nxt   = sh_r[0]; // lsb first
					sh_nxt    = sh_r >> 1;
					cnt_nxt   = 4'h1;
					state_nxt = ST_DATA;
				end
				ST_DATA: begin
					if (cnt_r == char_bits(cfg.size)) begin
						if (cfg.parity[1]) begin
							out_nxt   = par_r;
							state_nxt = ST_PAR;
						end else begin
							out_nxt   = 1'b1;
							stp_nxt   = 1'b0;
							state_nxt = ST_STOP;
						end
					end else begin
						out_nxt = sh_r[0];
						sh_nxt  = sh_r >> 1;
						cnt_nxt = cnt_r + 4'h1;
					end
				end
				ST_PAR: begin
					out_nxt   = 1'b1; // first stop bit follows parity
					stp_nxt   = 1'b0;
					state_nxt = ST_STOP;
				end
				ST_STOP: begin
					if (cfg.stop2 && !stp_r) begin
						stp_nxt = 1'b1; // second high stop bit
					end else begin
						load       = full_r;
						frame_done = !full_r;
						out_nxt    = 1'b1;
						state_nxt  = ST_IDLE;
					end
				end
			endcase
			if (load) begin
				sh_nxt    = masked;
				// even is the plain xor, bit0 of the mode inverts it
				par_nxt   = (^masked) ^ cfg.parity[0];
				out_nxt   = 1'b0; // start bit
				state_nxt = ST_START;
			end
		end
	end

	// ************************************************************
	// registers, all frozen while ce is low
	// ************************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_b_r <= RST_CTRL_B;
			ctrl_c_r <= RST_CTRL_C;
			dbl_r    <= 1'b0;
			baud_r   <= '0;
			ack_r    <= 1'b0;
			rdat_r   <= 32'h00000000;
			txc_r    <= 1'b0;
			full_r   <= 1'b0;
			buf_r    <= 9'h000;
			active_r <= 1'b0;
			irq_e_r  <= 1'b0;
			irq_c_r  <= 1'b0;
			ps_r     <= 5'h00;
			xck_r    <= 1'b0;
			xs1_r    <= 1'b0;
			xs2_r    <= 1'b0;
			xs3_r    <= 1'b0;
			state_r  <= ST_IDLE;
			sh_r     <= 9'h000;
			par_r    <= 1'b0;
			cnt_r    <= 4'h0;
			stp_r    <= 1'b0;
			out_r    <= 1'b1;
		end else if (ce) begin
			ctrl_b_r <= ctrl_b_nxt;
			ctrl_c_r <= ctrl_c_nxt;
			dbl_r    <= dbl_nxt;
			baud_r   <= baud_nxt;
			ack_r    <= ack_nxt;
			rdat_r   <= rdat_nxt;
			txc_r    <= txc_nxt;
			full_r   <= full_nxt;
			buf_r    <= buf_nxt;
			active_r <= active_nxt;
			irq_e_r  <= irq_e_nxt;
			irq_c_r  <= irq_c_nxt;
			ps_r     <= ps_nxt;
			xck_r    <= xck_nxt;
			xs1_r    <= xck_in;
			xs2_r    <= xs1_r;
			xs3_r    <= xs2_r;
			state_r  <= state_nxt;
			sh_r     <= sh_nxt;
			par_r    <= par_nxt;
			cnt_r    <= cnt_nxt;
			stp_r    <= stp_nxt;
			out_r    <= out_nxt;
		end
	end

	// pin drive registers: enables load from active_nxt and switch in the same cycle as active
	logic oe_n_r;  // serial pin drive
	logic xoe_n_r; // clock pin drive
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			oe_n_r  <= 1'b1;
			xoe_n_r <= 1'b1;
		end else if (ce) begin
			oe_n_r  <= !active_nxt;
			xoe_n_r <= !sync_master;
		end
	end

	assign wb_ack_o      = ack_r;
	assign wb_dat_o      = rdat_r;
	assign serial_out    = out_r;
	assign serial_oe_n   = oe_n_r;
	assign xck_out       = xck_r;
	assign xck_oe_n      = xoe_n_r;
	assign irq_buf_empty = irq_e_r;
	assign irq_tx_done   = irq_c_r;

endmodule // usx_tx
`default_nettype wire

// *** dv/usx_tx_chk.sv ***
/* checker: bus, pin and interrupt timing of the transmitter.
 assumes it is bound to usx_tx and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module usx_tx_chk
	import usx_pkg::*;
(
	input wire logic        clock,         // system clock
	input wire logic        rst_n,         // async reset, active low
	input wire logic        wb_cyc_i,      // bus cycle
	input wire logic        wb_stb_i,      // bus strobe
	input wire logic        wb_we_i,       // bus write
	input wire logic [4:0]  wb_adr_i,      // bus address
	input wire logic [3:0]  wb_sel_i,      // byte selects
	input wire logic [31:0] wb_dat_i,      // write data
	input wire logic        wb_ack_o,      // acknowledge
	input wire logic        serial_out,    // line level
	input wire logic        serial_oe_n,   // line drive, low driven
	input wire logic        xck_oe_n,      // clock pin drive
	input wire logic        txc_irq_ack,   // complete serviced
	input wire logic        irq_buf_empty, // empty request
	input wire logic        irq_tx_done    // complete request
);
	// ************************************************************
	// helpers
	// ************************************************************
	logic tk;     // request taken this edge
	logic wr;     // write taken this edge
	logic sync_r; // shadow of the sync mode bit
	assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = tk & wb_we_i & wb_sel_i[0];
	// shadow kept so bit-time checks skip the fast sync clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_r <= RST_CTRL_C[C_SYNC];
		end else if (wr && wb_adr_i == OFS_CTRL_C) begin
			sync_r <= wb_dat_i[C_SYNC];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ************************************************************
	// assertions
	// ************************************************************
	AST_ACK_LAT: assert property (tk |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_IDLE_HIGH: assert property (serial_oe_n |-> serial_out)
		else $error("released line not high");
	AST_BIT_MIN: assert property ($changed(serial_out) && !sync_r |=> $stable(serial_out)[*7])
		else $error("async bit too short");
	AST_EMPTY_HELD: assert property (irq_buf_empty && !wr && !$past(wr) |=> irq_buf_empty)
		else $error("empty request dropped");
	AST_TXC_ACK: assert property (txc_irq_ack && serial_oe_n |=> ##1 !irq_tx_done)
		else $error("service did not clear");
	AST_TXC_W1C: assert property (wr && wb_adr_i == OFS_CTRL_A && wb_dat_i[A_TX_COMPLETE]
		&& serial_oe_n |=> ##1 !irq_tx_done)
		else $error("write one did not clear");
	AST_XCK_OE: assert property (!xck_oe_n |-> sync_r || $past(sync_r))
		else $error("clock pin driven in async");
	C_DATA: cover property (wr && wb_adr_i == OFS_DATA);
	C_START: cover property ($fell(serial_out));
	C_XCK: cover property (!xck_oe_n);
endmodule // usx_tx_chk
bind usx_tx usx_tx_chk u_usx_tx_chk (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .serial_out, .serial_oe_n, .xck_oe_n,
	.txc_irq_ack, .irq_buf_empty, .irq_tx_done);
`default_nettype wire

// *** dv/usx_rx_model.sv ***
/* remote receiver: samples the line mid-bit, 16 clocks a bit.
 assumes the bench sets nb, the bit count with start, before each frame. */
`timescale 1ns/1ns
`default_nettype none
module usx_rx_model (
	input  wire logic       clock, // system clock
	input  wire logic       rst_n, // reset, active low
	input  wire logic       line,  // serial line
	input  wire logic [3:0] nb,    // bits to take, start included
	output logic      [15:0] bits, // bit i of frame at index i
	output logic      [7:0]  cnt   // frames taken
);
	// ************************************************************
	// framing
	// ************************************************************
	logic prev; // line one edge ago
	// one process owns every output, so each has a single driver
	// re-arms at mid stop so a back-to-back start is not missed
	initial begin
		bits = 16'h0000;
		cnt = 8'h00;
		prev = 1'b1;
		forever begin
			@(posedge clock);
			if (rst_n && prev && !line) begin
				repeat (7) @(posedge clock);
				for (int i = 0; i < nb; i++) begin
					bits[i] = line;
					if (i < nb - 1) repeat (16) @(posedge clock);
				end
				cnt = cnt + 8'h01;
			end
			prev = line;
		end
	end
endmodule // usx_rx_model
`default_nettype wire

// *** dv/usx_tx_tb.sv ***
/* bench: drives the transmitter over wishbone, judges the line.
 assumes usx_rx_model on the serial pin and divisor 0 by default. */
`timescale 1ns/1ns
`default_nettype none
module usx_tx_tb;
	import usx_pkg::*;
	logic clock = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, txc_ack = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [3:0] sel = 4'hF, nb = 4'hA;
	logic [31:0] wdat = 32'h0, rdat;
	logic ack, sout, soe_n, xout, xoe_n, ie_buf, ie_txc;
	logic [15:0] rxb;
	logic [7:0] rx_complete_flag, n0, d;
	int n_errors = 0, samples_checked = 0, cyc_n = 0;
	always #5 clock = ~clock;
	usx_tx u_usx_tx (.clock, .rst_n, .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .serial_out(sout), .serial_oe_n(soe_n), .xck_in(1'b0),
		.xck_out(xout), .xck_oe_n(xoe_n), .txc_irq_ack(txc_ack),
		.irq_buf_empty(ie_buf), .irq_tx_done(ie_txc));
	usx_rx_model u_usx_rx_model (.clock, .rst_n, .line(sout), .nb, .bits(rxb), .cnt(rx_complete_flag));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic report_and_stop;
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one classic cycle; held until ack is sampled high
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
		@(posedge clock);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, v};
		do @(posedge clock); while (ack !== 1'b1);
		d = rdat[7:0];
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string nm);
		bus(1'b0, a, 8'h00);
		chk(nm, {8'h0, d}, {8'h0, e});
	endtask
	task automatic wait_frm(input logic [7:0] n);
		repeat (4000) if (rx_complete_flag < n) @(posedge clock);
		chk("frame count", {8'h0, rx_complete_flag}, {8'h0, n});
	endtask
	// polls status until nothing is in flight or pending, so format may change
	task automatic wait_done;
		do bus(1'b0, OFS_CTRL_A, 8'h00); while (!d[A_TX_COMPLETE]);
	endtask
	// sends one character and compares the whole frame on the line
	task automatic frame(input logic [8:0] v, input int nd, pe, po, ns);
		logic [15:0] e, m;
		logic x;
		int p;
		e = 16'hFFFF; e[0] = 1'b0; x = po[0];
		for (int i = 0; i < nd; i++) begin
			e[1 + i] = v[i];
			x ^= v[i];
		end
		p = 1 + nd;
		if (pe) begin
			e[p] = x;
			p++;
		end
		p += ns;
		m = (16'h1 << p) - 16'h1;
		nb = p[3:0]; n0 = rx_complete_flag;
		bus(1'b0, OFS_CTRL_A, 8'h00);
		// keep double speed, clear complete, write the empty flag as zero
		bus(1'b1, OFS_CTRL_A, (d & 8'h02) | 8'h40);
		bus(1'b1, OFS_DATA, v[7:0]);
		wait_frm(n0 + 8'h01);
		chk("frame", rxb & m, e & m);
		wait_done();
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		rdc(OFS_CTRL_A, 8'h20, "status a");
		rdc(OFS_CTRL_B, RST_CTRL_B, "ctrl b");
		rdc(OFS_CTRL_C, RST_CTRL_C, "ctrl c");
		rdc(5'h18, 8'h00, "unmapped");
		chk("idle pins", {14'h0, sout, soe_n}, 16'h3);
	endtask
	task automatic t_basic;
		bus(1'b1, OFS_CTRL_B, 8'h08);
		repeat (3) @(posedge clock);
		chk("line drive", {15'h0, soe_n}, 16'h0);
		frame(9'h0A5, 8, 0, 0, 1);
		repeat (12) @(posedge clock);
		rdc(OFS_CTRL_A, 8'h60, "done flags");
	endtask
	task automatic t_parity;
		logic [1:0] m [3] = '{2'b10, 2'b11, 2'b01};
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, OFS_CTRL_C, {1'b0, m[k], 1'b0, 3'h2, 1'b0});
			frame(9'h0D3, 7, m[k][1], m[k][0], 1);
		end
	endtask
	task automatic t_nine;
		bus(1'b1, OFS_CTRL_B, 8'h09);
		bus(1'b1, OFS_CTRL_C, 8'h5E);
		bus(1'b1, OFS_CTRL_A, 8'h02);
		bus(1'b1, OFS_BAUD_HI, 8'h00);
		bus(1'b1, OFS_BAUD_LO, 8'h01);
		frame(9'h13C, 9, 1, 0, 2);
		bus(1'b1, OFS_CTRL_A, 8'h00);
		bus(1'b1, OFS_BAUD_LO, 8'h00);
		bus(1'b1, OFS_CTRL_B, 8'h08);
		bus(1'b1, OFS_CTRL_C, RST_CTRL_C);
	endtask
	task automatic t_b2b;
		nb = 4'hA; n0 = rx_complete_flag;
		bus(1'b1, OFS_CTRL_A, 8'h40);
		bus(1'b1, OFS_DATA, 8'h0F);
		repeat (50) begin
			bus(1'b0, OFS_CTRL_A, 8'h00);
			if (d[A_BUF_EMPTY]) break;
		end
		bus(1'b1, OFS_DATA, 8'hF0);
		rdc(OFS_CTRL_A, 8'h00, "buffer full");
		wait_frm(n0 + 8'h02);
		chk("second frame", rxb & 16'h3FF, {6'h0, 1'b1, 8'hF0, 1'b0});
		wait_done();
	endtask
	task automatic t_irq;
		bus(1'b1, OFS_CTRL_B, 8'h68);
		repeat (2) @(posedge clock);
		chk("empty request", {15'h0, ie_buf}, 16'h1);
		chk("done request", {15'h0, ie_txc}, 16'h1);
		bus(1'b1, OFS_CTRL_A, 8'h40);
		repeat (2) @(posedge clock);
		chk("done cleared", {15'h0, ie_txc}, 16'h0);
		frame(9'h081, 8, 0, 0, 1);
		repeat (12) @(posedge clock);
		chk("done again", {15'h0, ie_txc}, 16'h1);
		txc_ack <= 1'b1;
		@(posedge clock);
		txc_ack <= 1'b0;
		repeat (2) @(posedge clock);
		chk("serviced", {15'h0, ie_txc}, 16'h0);
		chk("empty held", {15'h0, ie_buf}, 16'h1);
	endtask
	task automatic t_disable;
		nb = 4'hA; n0 = rx_complete_flag;
		bus(1'b1, OFS_DATA, 8'h55);
		bus(1'b1, OFS_CTRL_B, 8'h40);
		repeat (2) @(posedge clock);
		chk("held drive", {15'h0, soe_n}, 16'h0);
		wait_frm(n0 + 8'h01);
		chk("last frame", rxb & 16'h3FF, {6'h0, 1'b1, 8'h55, 1'b0});
		repeat (12) @(posedge clock);
		chk("released", {15'h0, soe_n}, 16'h1);
		chk("done request", {15'h0, ie_txc}, 16'h1);
		bus(1'b1, OFS_CTRL_A, 8'h40);
		chk("done written off", {15'h0, ie_txc}, 16'h0);
		txc_ack <= 1'b1;
		@(posedge clock);
		txc_ack <= 1'b0;
	endtask
	task automatic t_sync;
		int t;
		logic p;
		bus(1'b1, OFS_CTRL_C, 8'h86);
		bus(1'b1, OFS_CTRL_B, 8'h0A);
		repeat (3) @(posedge clock);
		chk("clock pin drive", {15'h0, xoe_n}, 16'h0);
		bus(1'b1, OFS_DATA, 8'h3C);
		t = 0; p = xout;
		repeat (40) begin
			@(posedge clock);
			if (xout !== p) t++;
			p = xout;
		end
		chk("clock pin edges", {15'h0, t > 3}, 16'h1);
	endtask
	// ************************************************************
	// sequence and timeout
	// ************************************************************
	always @(posedge clock) begin
		cyc_n++;
		if (cyc_n == 30000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_basic();
		t_parity();
		t_nine();
		t_b2b();
		t_irq();
		t_disable();
		t_sync();
		report_and_stop();
	end
endmodule // usx_tx_tb
`default_nettype wire
